// ---- include/epc_defines.vh ----
// Constants for the easy pin configuration setup block
`ifndef EPC_DEFINES_VH
`define EPC_DEFINES_VH

// Register offsets
`define EPC_REG_CTRL 8'h01
`define EPC_REG_PCFG0 8'h10
`define EPC_REG_PCFG3 8'h13
`define EPC_REG_PRESET 8'h14

// Field positions and widths
`define EPC_CTRL_SETUP_BIT 5
`define EPC_PRESET_W 5

// Reset values
`define EPC_CTRL_RST 8'h00
`define EPC_PRESET_RST 8'h01

// Pin configuration images per preset, {pcfg3,pcfg2,pcfg1,pcfg0}
`define EPC_OPT1_CFG 32'hAC42CE7F
`define EPC_OPT2_CFG 32'hAC28CC7F
`define EPC_OPT3_CFG 32'h0012001E
`define EPC_OPT4_CFG 32'h00000000
`define EPC_OPT5_CFG 32'h00000000

// Bus address, arbitrary value
`define EPC_SLV_ADDR 7'h2C

// Timing
`define EPC_CLK_KHZ 10000
`define EPC_TOUT_MS 25
`define EPC_SCAN_US 100
`define EPC_TOUT_CYC (`EPC_TOUT_MS * `EPC_CLK_KHZ)
`define EPC_SCAN_CYC ((`EPC_SCAN_US * `EPC_CLK_KHZ) / 1000)

`endif

// ---- logic/epc_scl_timeout.v ----
// Clock-low timeout detector for the serial bus clock
`timescale 1ns/100ps
`default_nettype none
module epc_scl_timeout #(
   parameter CNT_W = 18,
   parameter LIMIT = 250000
)(
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Control and status
   input wire enable,
   input wire scl_low,
   output reg hit
);
   reg [CNT_W-1:0] cnt_q;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         cnt_q <= {CNT_W{1'b0}};
         hit <= 1'b0;
      end
      else
      begin
         hit <= 1'b0;
         if (!enable || !scl_low)
            cnt_q <= {CNT_W{1'b0}};
         // Saturate so one hold gives one pulse
         else if (cnt_q != LIMIT[CNT_W-1:0])
         begin
            cnt_q <= cnt_q + 1'b1;
            if (cnt_q == LIMIT[CNT_W-1:0] - 1'b1)
               hit <= 1'b1;
         end
      end
   end
endmodule // epc_scl_timeout
`default_nettype wire

// ---- logic/epc_top.v ----
// Serial-bus register slave with preset pin configuration and scan start
`timescale 1ns/100ps
`default_nettype none
`include "epc_defines.vh"
module epc_top #(
   parameter TOUT_CYC = `EPC_TOUT_CYC,
   parameter SCAN_CYC = `EPC_SCAN_CYC
)(
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Serial bus pins
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output reg sda_oe,
   // Options
   input wire timeout_en,
   // Configuration and monitor state
   output wire [31:0] pin_cfg,
   output wire setup_done,
   output reg [4:0] mon_chan,
   output reg mon_strobe
);
   localparam ST_IDLE = 3'd0;
   localparam ST_ADDR = 3'd1;
   localparam ST_PTR = 3'd2;
   localparam ST_WDATA = 3'd3;
   localparam ST_RDATA = 3'd4;
   localparam ST_ACK = 3'd5;
   localparam ST_RACK = 3'd6;

   reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
   reg [2:0] state_q, next_q;
   reg [2:0] bit_cnt;
   reg [7:0] shreg, ptr_q;
   reg got_byte;
   reg wr_q;
   reg [7:0] wr_addr_q, wr_data_q;
   reg [7:0] ctrl_q, preset_q;
   reg [7:0] pcfg_q [0:3];
   reg [15:0] div_q;
   wire scl_rise, scl_fall, start_c, stop_c, tout_hit, scan_tick;
   // Whole images, so each register takes an explicit byte slice
   wire [31:0] rst_img = `EPC_OPT1_CFG;
   wire [31:0] new_img = preset_img(wr_data_q[4:0]);
   wire [7:0] rd_now = rd_mux(ptr_q);
   integer i;

   // Open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign pin_cfg = {pcfg_q[3], pcfg_q[2], pcfg_q[1], pcfg_q[0]};
   assign setup_done = ctrl_q[`EPC_CTRL_SETUP_BIT];

   // Lowest set bit wins if the host breaks the one-hot convention
   function [31:0] preset_img;
      input [4:0] sel;
      begin
         if (sel[0])
            preset_img = `EPC_OPT1_CFG;
         else if (sel[1])
            preset_img = `EPC_OPT2_CFG;
         else if (sel[2])
            preset_img = `EPC_OPT3_CFG;
         else if (sel[3])
            preset_img = `EPC_OPT4_CFG;
         else
            preset_img = `EPC_OPT5_CFG;
      end
   endfunction

   function [7:0] rd_mux;
      input [7:0] a;
      begin
         if (a == `EPC_REG_CTRL)
            rd_mux = ctrl_q;
         else if (a == `EPC_REG_PRESET)
            rd_mux = preset_q;
         else if (a >= `EPC_REG_PCFG0 && a <= `EPC_REG_PCFG3)
            rd_mux = pcfg_q[a[1:0]];
         else
            rd_mux = 8'h00;
      end
   endfunction

   // Pin synchronisers; edges read only the second stage onward
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
      end
      else
      begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_p;
   assign scl_fall = ~scl_s & scl_p;
   assign start_c = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_c = scl_s & scl_p & ~sda_p & sda_s;

   epc_scl_timeout #(
      .CNT_W(18),
      .LIMIT(TOUT_CYC)
   ) u_tout (
      .sys_clk(sys_clk),
      .rst(rst),
      .enable(timeout_en),
      .scl_low(~scl_s),
      .hit(tout_hit)
   );

   // Bus slave byte engine
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         next_q <= ST_IDLE;
         bit_cnt <= 3'd0;
         shreg <= 8'h00;
         ptr_q <= 8'h00;
         got_byte <= 1'b0;
         sda_oe <= 1'b0;
         wr_q <= 1'b0;
         wr_addr_q <= 8'h00;
         wr_data_q <= 8'h00;
      end
      else
      begin
         wr_q <= 1'b0;
         if (tout_hit || stop_c)
         begin
            state_q <= ST_IDLE;
            sda_oe <= 1'b0;
            got_byte <= 1'b0;
         end
         else if (start_c)
         begin
            state_q <= ST_ADDR;
            bit_cnt <= 3'd0;
            got_byte <= 1'b0;
            sda_oe <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_ADDR, ST_PTR, ST_WDATA:
               begin
                  if (scl_rise)
                  begin
                     shreg <= {shreg[6:0], sda_s};
                     bit_cnt <= bit_cnt + 1'b1;
                     if (bit_cnt == 3'd7)
                        got_byte <= 1'b1;
                  end
                  else if (scl_fall && got_byte)
                  begin
                     got_byte <= 1'b0;
                     sda_oe <= 1'b1;
                     state_q <= ST_ACK;
                     if (state_q == ST_ADDR)
                     begin
                        if (shreg[7:1] != `EPC_SLV_ADDR)
                        begin
                           sda_oe <= 1'b0;
                           state_q <= ST_IDLE;
                        end
                        next_q <= shreg[0] ? ST_RDATA : ST_PTR;
                     end
                     else if (state_q == ST_PTR)
                     begin
                        ptr_q <= shreg;
                        next_q <= ST_WDATA;
                     end
                     else
                     begin
                        wr_q <= 1'b1;
                        wr_addr_q <= ptr_q;
                        wr_data_q <= shreg;
                        ptr_q <= ptr_q + 1'b1;
                        next_q <= ST_WDATA;
                     end
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     state_q <= next_q;
                     bit_cnt <= 3'd0;
                     if (next_q == ST_RDATA)
                     begin
                        shreg <= rd_now;
                        sda_oe <= ~rd_now[7];
                        ptr_q <= ptr_q + 1'b1;
                     end
                     else
                        sda_oe <= 1'b0;
                  end
               end
               ST_RDATA:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt <= bit_cnt + 1'b1;
                     if (bit_cnt == 3'd7)
                     begin
                        sda_oe <= 1'b0;
                        state_q <= ST_RACK;
                     end
                     else
                     begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                     end
                  end
               end
               ST_RACK:
               begin
                  if (scl_rise)
                     got_byte <= ~sda_s;
                  else if (scl_fall)
                  begin
                     got_byte <= 1'b0;
                     bit_cnt <= 3'd0;
                     if (got_byte)
                     begin
                        state_q <= ST_RDATA;
                        shreg <= rd_now;
                        sda_oe <= ~rd_now[7];
                        ptr_q <= ptr_q + 1'b1;
                     end
                     else
                        state_q <= ST_IDLE;
                  end
               end
               default:
               begin
                  sda_oe <= 1'b0;
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Register file
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         ctrl_q <= `EPC_CTRL_RST;
         preset_q <= `EPC_PRESET_RST;
         for (i = 0; i < 4; i = i + 1)
            pcfg_q[i] <= rst_img[8 * i +: 8];
      end
      else if (wr_q)
      begin
         if (wr_addr_q == `EPC_REG_CTRL)
            ctrl_q <= wr_data_q;
         else if (wr_addr_q == `EPC_REG_PRESET)
         begin
            preset_q <= wr_data_q & 8'h1F;
            if (wr_data_q[`EPC_PRESET_W-1:0] != 5'h00)
               for (i = 0; i < 4; i = i + 1)
                  pcfg_q[i] <= new_img[8 * i +: 8];
         end
         else if (wr_addr_q >= `EPC_REG_PCFG0 &&
                  wr_addr_q <= `EPC_REG_PCFG3)
            pcfg_q[wr_addr_q[1:0]] <= wr_data_q;
      end
   end

   // Channel scan timebase
   assign scan_tick = (div_q == SCAN_CYC[15:0] - 16'h0001);

   always @(posedge sys_clk)
   begin
      if (rst || !setup_done)
      begin
         div_q <= 16'h0000;
         mon_chan <= 5'h00;
         mon_strobe <= 1'b0;
      end
      else
      begin
         mon_strobe <= 1'b0;
         if (scan_tick)
         begin
            div_q <= 16'h0000;
            mon_chan <= mon_chan + 1'b1;
            mon_strobe <= pin_cfg[mon_chan + 1'b1];
         end
         else
            div_q <= div_q + 1'b1;
      end
   end
endmodule // epc_top
`default_nettype wire

// ---- verif/epc_checker_assertions.sv ----
// Port-level checks for the pin preset and setup block
`timescale 1ns/100ps
`default_nettype none
`include "epc_defines.vh"
module epc_checker #(
   parameter int TOUT_CYC = `EPC_TOUT_CYC,
   parameter int SCAN_CYC = `EPC_SCAN_CYC
)(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Bus pins and option
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic timeout_en,
   // Configuration and monitor
   input wire logic [31:0] pin_cfg,
   input wire logic setup_done,
   input wire logic [4:0] mon_chan,
   input wire logic mon_strobe
);
   // Margin covers the pin synchronisers
   localparam int SCAN_HI = SCAN_CYC + 3;
   localparam int TOUT_HI = TOUT_CYC + 6;
   logic [19:0] low_q;
   logic [19:0] low_d;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Saturates so a stuck clock cannot wrap the count
   always_comb
      low_d = (scl_in | ~timeout_en) ? 20'h00000 :
         low_q + {19'h0, ~&low_q};
   always_ff @(posedge sys_clk)
      if (rst)
         low_q <= 20'h00000;
      else
         low_q <= low_d;
   a_reset_preset: assert property ($fell(rst) |->
      pin_cfg == `EPC_OPT1_CFG && !setup_done && mon_chan == 5'h00)
      else $error("pin state after reset is not preset one");
   a_strobe_setup: assert property (mon_strobe |-> setup_done)
      else $error("channel measured before setup complete");
   a_chan_idle: assert property (!setup_done && !$past(setup_done) |->
      mon_chan == 5'h00) else $error("scan index moved without setup");
   a_strobe_enabled: assert property (mon_strobe |-> pin_cfg[mon_chan])
      else $error("disabled channel measured");
   a_scan_start: assert property ($rose(setup_done) |->
      ##[1:SCAN_HI] (mon_chan == 5'h01 || !setup_done))
      else $error("scan did not start after setup");
   a_scan_step: assert property (setup_done && $past(setup_done) &&
      $changed(mon_chan) |-> mon_chan - $past(mon_chan) == 5'h01)
      else $error("scan index did not step by one");
   a_timeout_idle: assert property (low_q > TOUT_HI |-> !sda_oe)
      else $error("slave still drives after clock-low timeout");
   a_cfg_from_bus: assert property ($changed(pin_cfg) |->
      $past(sda_oe) || $past(sda_oe, 2))
      else $error("pin configuration changed without a bus write");
   a_setup_from_bus: assert property ($changed(setup_done) |->
      $past(sda_oe) || $past(sda_oe, 2))
      else $error("setup flag changed without a bus write");
   c_strobe: cover property (mon_strobe);
   c_timeout: cover property (low_q > TOUT_HI);
   c_cfg: cover property ($changed(pin_cfg));
endmodule // epc_checker
bind epc_top epc_checker #(.TOUT_CYC(TOUT_CYC), .SCAN_CYC(SCAN_CYC)) chk_i (
   .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .timeout_en(timeout_en),
   .pin_cfg(pin_cfg), .setup_done(setup_done), .mon_chan(mon_chan),
   .mon_strobe(mon_strobe));
`default_nettype wire

// ---- verif/epc_host.sv ----
// Bus host model driving clock and open-drain data
`timescale 1ns/100ps
`default_nettype none
module epc_host (
   // Clock and bus
   input wire logic sys_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   // Read results
   output logic [7:0] rd_data,
   output logic rd_valid
);
   logic r;
   int naks = 0;
   initial
   begin
      scl = 1;
      sda_low = 0;
      rd_valid = 0;
      rd_data = 8'h00;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   // Phases of 5 cycles keep the 4-cycle minimum
   task automatic put(input logic b);
      sda_low = ~b;
      wt(5);
      scl = 1;
      wt(5);
      r = sda;
      scl = 0;
      wt(2);
   endtask
   task automatic start();
      sda_low = 0;
      wt(3);
      scl = 1;
      wt(5);
      sda_low = 1;
      wt(5);
      scl = 0;
      wt(2);
   endtask
   task automatic stop();
      sda_low = 1;
      wt(3);
      scl = 1;
      wt(5);
      sda_low = 0;
      wt(5);
   endtask
   task automatic bits(input logic [7:0] d);
      for (int i = 7; i >= 0; i--)
         put(d[i]);
   endtask
   task automatic send(input logic [7:0] d);
      bits(d);
      put(1'b1);
      if (r !== 1'b0)
         naks++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      send(8'h58);
      send(a);
      send(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] a);
      start();
      send(8'h58);
      send(a);
      start();
      send(8'h59);
      for (int i = 7; i >= 0; i--)
      begin
         put(1'b1);
         rd_data[i] = r;
      end
      put(1'b1);
      stop();
      rd_valid = 1;
      wt(1);
      rd_valid = 0;
   endtask
endmodule // epc_host
`default_nettype wire

// ---- verif/tb_easy_pin_config_setup.sv ----
// Self-checking bench for the pin preset and setup block
`timescale 1ns/100ps
`default_nettype none
`include "epc_defines.vh"
module tb_easy_pin_config_setup;
   localparam logic [31:0] CFG [5] = '{`EPC_OPT1_CFG, `EPC_OPT2_CFG,
      `EPC_OPT3_CFG, `EPC_OPT4_CFG, `EPC_OPT5_CFG};
   logic sys_clk = 0;
   logic rst = 1;
   logic timeout_en = 0;
   logic scl, sda_low, sda_oe, sda_out, setup_done, mon_strobe, rd_valid;
   logic [31:0] pin_cfg;
   logic [4:0] mon_chan;
   logic [7:0] rd_data, wb;
   logic [7:0] exp_q [$];
   int mismatches = 0;
   int tests_run = 0;
   int seed = 37298;
   int strobes = 0;
   // Pull-up wins unless a party pulls low
   wire logic sda = ~sda_low & (~sda_oe | sda_out);
   epc_top #(.TOUT_CYC(50), .SCAN_CYC(8)) dut (.sys_clk(sys_clk),
      .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .timeout_en(timeout_en), .pin_cfg(pin_cfg),
      .setup_done(setup_done), .mon_chan(mon_chan),
      .mon_strobe(mon_strobe));
   epc_host host (.sys_clk(sys_clk), .sda(sda), .scl(scl),
      .sda_low(sda_low), .rd_data(rd_data), .rd_valid(rd_valid));
   initial
      forever #50 sys_clk = ~sys_clk;
   always @(posedge sys_clk)
      if (mon_strobe === 1'b1)
         strobes++;
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         mismatches++;
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.rd(a);
   endtask
   always @(posedge rd_valid)
      chk("read data", exp_q.pop_front(), rd_data);
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      #4000000;
      mismatches++;
      wrap_up();
   end
   initial
   begin
      wb = 8'($random(seed));
      host.wt(6);
      rst = 0;
      host.wt(3);
      chk("reset cfg", `EPC_OPT1_CFG, pin_cfg); // preset one
      rd(8'h14, 8'h01); // selector reset
      rd(8'h01, 8'h00); // setup clear
      rd(8'h33, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         host.wr(8'h14, 8'h01 << i); // one bit
         host.wt(3);
         chk("preset cfg", CFG[i], pin_cfg); // image
         rd(8'h14, 8'h01 << i); // selector
      end
      host.wr(8'h14, 8'h01);
      host.wr(8'h10, wb); // override
      host.wt(3);
      chk("override", {CFG[0][31:8], wb}, pin_cfg); // low byte, pins 0 to 7
      chk("early strobes", 0, strobes); // no scan
      host.wr(8'h01, 8'h20); // setup complete
      chk("setup", 1, setup_done); // flag set
      host.wt(300);
      chk("scan strobes", 1, strobes > 0); // scan runs
      host.wr(8'h01, 8'h00);
      host.wt(3);
      chk("scan stopped", 0, {setup_done, mon_chan}); // idle
      host.start();
      host.bits(8'h58);
      host.wt(60);
      chk("ack held", 1, sda_oe); // disabled
      timeout_en = 1;
      host.wt(60);
      chk("ack dropped", 0, sda_oe); // abandon
      timeout_en = 0;
      host.stop();
      rd(8'h10, wb); // back to idle
      chk("naks", 0, host.naks);
      host.wt(5);
      wrap_up();
   end
endmodule // tb_easy_pin_config_setup
`default_nettype wire
